// file: dv/cmr_mem_model.sv
// shared memory partner that answers sequencer reads
`timescale 1ns/1ps
module cmr_mem_model (
    input wire logic i_clock, // core clock
    input wire logic i_rd, // read strobe
    input wire logic [15:0] i_addr, // read address
    output logic [15:0] o_rdata, // read data
    output logic o_rvalid // read data valid
);
    logic [15:0] addr_hold = 16'h0000;
    logic [15:0] churn = 16'h0000;
    logic [3:0] wait_left = 4'h0;
    logic slow = 1'b0;
    // prompt and slow answers by turns; data is the inverted address
    // idle data churns so a stale word is never mistaken for an answer
    always @(posedge i_clock) begin
        churn <= churn + 16'h0001;
        o_rvalid <= (wait_left == 4'h1);
        o_rdata <= (wait_left == 4'h1) ? ~addr_hold : churn;
        if (i_rd) begin
            addr_hold <= i_addr;
            wait_left <= slow ? 4'h5 : 4'h1;
            slow <= ~slow;
        end else if (wait_left != 4'h0) begin
            wait_left <= wait_left - 4'h1;
        end
    end
endmodule // cmr_mem_model

// file: dv/tb_top.sv
// self-checking bench for the message result and queue block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
    fail_count++; $display("CHECK FAILED %s exp %h got %h", nm, ex, got); \
    end end
module tb_top;
    import cmr_pkg::*;
    logic i_clock, i_reset, i_reg_write, i_msg_start, i_msg_bus_b;
    logic i_msg_terminal_to_terminal_transfer, i_broadcast_received_bit_mask_mode, i_msg_end, i_res_line_busy;
    logic i_res_order_err, i_res_fmt, i_res_timeout, i_res_loop_fail;
    logic i_res_good_type, i_res_status_valid, i_q_push, i_frame_auto;
    logic i_frame_end, i_frame_start, i_mem_rvalid;
    logic [7:0] i_reg_addr;
    logic [3:0] i_res_cause;
    logic [1:0] i_res_retries, i_q_kind;
    logic [15:0] i_reg_wdata, i_msg_block, i_ctrl_word, i_gap_us;
    logic [15:0] i_res_status, i_res_status2, i_res_echo, i_time_tag;
    logic [15:0] i_q_param, i_mem_rdata, o_reg_rdata, o_mem_addr;
    logic [15:0] o_mem_wdata, qptr, last_bsw;
    logic o_msg_complete, o_next_msg_go, o_q_busy, o_q_wrap;
    logic o_frame_restart, o_mem_wr, o_mem_rd;
    logic [31:0] exp_q[$];
    int fail_count = 0;
    int n_compared = 0;
    int seed = 98;
    cmr_result_queue dut_u (.*);
    cmr_mem_model mem_u (.i_clock(i_clock), .i_rd(o_mem_rd),
        .i_addr(o_mem_addr), .o_rdata(i_mem_rdata), .o_rvalid(i_mem_rvalid));
    always #12.5 i_clock = ~i_clock;
    // every memory write is matched against the oldest expected word
    always @(posedge i_clock) begin
        if (o_mem_wr === 1'b1) begin
            `CHK("extra_wr", 1, exp_q.size() > 0)
            `CHK("mem_addr", exp_q[0][31:16], o_mem_addr)
            `CHK("mem_data", exp_q[0][15:0], o_mem_wdata)
            void'(exp_q.pop_front());
        end
    end
    task automatic tally_and_finish();
        $display("compared %0d failed %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // rdata is registered, so the answer is looked at two edges on
    task automatic reg_acc(input logic [7:0] a, input logic w,
                           input logic [15:0] d, input logic [15:0] x);
        i_reg_addr = a;
        i_reg_write = w;
        i_reg_wdata = d;
        @(negedge i_clock) i_reg_write = 1'b0;
        @(negedge i_clock) `CHK("reg_rdata", x, o_reg_rdata)
    endtask
    // status word expected from the result inputs
    function automatic logic [15:0] bsw_of();
        logic [15:0] s;
        logic [15:0] c;
        logic hard;
        logic unm;
        logic sts;
        s = i_res_status;
        c = i_ctrl_word;
        hard = i_res_fmt | i_res_timeout | (|i_res_cause) | i_res_line_busy
            | i_res_order_err;
        unm = (|s[10:9]) | s[1] | (s[8] & ~c[13]) | (s[3] & ~c[12])
            | (s[2] & ~c[11]) | (s[0] & ~c[10]) | ((|s[7:5]) & ~c[9])
            | (i_broadcast_received_bit_mask_mode & s[4] & ~c[5]);
        sts = (|s[10:5]) | (|s[3:0])
            | (i_broadcast_received_bit_mask_mode ? s[4] & ~c[5] : s[4] ^ c[5]);
        return {2'b11, i_msg_bus_b, hard | i_res_loop_fail, sts, i_res_fmt,
            i_res_timeout, i_res_loop_fail, unm, i_res_retries == 2'd2,
            i_res_retries == 2'd1, i_res_good_type & ~hard, i_res_cause};
    endfunction
    task automatic message(input logic rt, input logic [15:0] g);
        logic [15:0] blk;
        logic [31:0] r;
        int n;
        int e;
        int done;
        blk = 16'($random(seed));
        i_msg_block = blk;
        blk[2:0] = 3'b000;
        {i_msg_bus_b, i_msg_terminal_to_terminal_transfer, i_gap_us} = {blk[3], rt, g};
        exp_q.push_back({blk | WRD_BSW, 2'b01, blk[3], 13'h0000});
        i_msg_start = 1'b1;
        {i_res_status, i_res_status2, r} = {$random(seed), $random(seed)};
        {i_ctrl_word, i_res_echo, r} = {$random(seed), $random(seed)};
        r = $random(seed);
        {i_res_fmt, i_res_timeout, i_res_loop_fail, i_res_line_busy,
            i_res_order_err} = r[4:0] & r[9:5] & r[14:10];
        i_res_cause = r[18:15] & {4{r[19]}} & r[23:20];
        // the timed message always meets a busy line
        i_res_line_busy |= (g != 16'h0000);
        // a refused message never saw a reply, so no cause bits
        if (i_res_line_busy | i_res_order_err) i_res_cause = 4'h0;
        i_res_retries = (r[25:24] == 2'b11) ? 2'b10 : r[25:24];
        {i_res_good_type, i_broadcast_received_bit_mask_mode} = r[27:26];
        @(negedge i_clock) i_msg_start = 1'b0;
        repeat (2) @(negedge i_clock);
        last_bsw = bsw_of();
        exp_q.push_back({blk | WRD_ECHO, i_res_echo});
        exp_q.push_back({blk | WRD_STAT, i_res_status});
        if (rt) exp_q.push_back({blk | WRD_STAT2, i_res_status2});
        exp_q.push_back({blk | WRD_BSW, last_bsw});
        i_msg_end = 1'b1;
        @(negedge i_clock) i_msg_end = 1'b0;
        n = 4;
        done = 0;
        while (n < 1400 && o_next_msg_go !== 1'b1) begin
            if (o_msg_complete === 1'b1) begin
                done++;
                `CHK("pending_wr", 0, exp_q.size())
            end
            @(negedge i_clock);
            n++;
        end
        `CHK("complete", 1, done)
        e = (g == 16'h0000) ? GAP_CYCLES + 3 : g * US_CYCLES;
        `CHK("gap", 1, n >= e - 1 && n <= e + 4)
    endtask
    task automatic push(input logic [1:0] k, input logic [15:0] p,
                        input logic [15:0] d);
        logic wrap_seen;
        int n;
        exp_q.push_back({qptr, d});
        {i_q_kind, i_q_param, i_q_push, wrap_seen} = {k, p, 2'b10};
        @(negedge i_clock) i_q_push = 1'b0;
        for (n = 0; n < 40 && (o_q_busy !== 1'b0 || n < 2); n++)
            @(negedge i_clock) wrap_seen |= o_q_wrap;
        `CHK("q_wrap", qptr[5:0] == QLOW_LAST, wrap_seen)
        qptr[5:0] = qptr[5:0] + 6'h01;
    endtask
    initial begin
        {i_clock, i_reset, i_reg_write, i_msg_start, i_msg_end} = 5'b01000;
        {i_q_push, i_frame_auto, i_frame_end, i_frame_start} = 4'h0;
        {i_reg_addr, i_reg_wdata, i_q_kind, i_q_param} = 42'h0;
        {i_res_status_valid, i_time_tag} = {1'b1, 16'h5a3c};
        repeat (6) @(negedge i_clock);
        i_reset = 1'b0;
        reg_acc(QPTR_OFS, 1'b0, 16'h0000, QPTR_RESET);
        reg_acc(8'h1e, 1'b1, 16'hffff, 16'h0000);
        reg_acc(QPTR_OFS, 1'b1, 16'hf03d, 16'hf03d);
        qptr = 16'hf03d;
        // busy line, order, retries and masks come from the random mix
        message(1'b0, 16'h0000);
        message(1'b1, 16'h0014);
        for (int i = 0; i < 5; i++) message(i[0], 16'h0000);
        push(2'b10, 16'h1234, 16'h1234);
        push(2'b00, 16'h0000, i_time_tag);
        push(2'b11, 16'h0c40, 16'hf3bf);
        push(2'b01, 16'h0000, last_bsw);
        reg_acc(QPTR_OFS, 1'b0, 16'h0000, qptr);
        // auto repeat, end without auto, then host start
        for (int i = 0; i < 3; i++) begin
            {i_frame_auto, i_frame_end, i_frame_start} =
                (i == 0) ? 3'b110 : 3'b100 >> i;
            @(negedge i_clock) {i_frame_end, i_frame_start} = 2'b00;
            `CHK("restart", i != 1, o_frame_restart)
        end
        repeat (4) @(negedge i_clock);
        `CHK("leftover", 0, exp_q.size())
        tally_and_finish();
    end
    // hang guard sized well beyond the expected run of about 3300 cycles
    initial begin
        #(25 * 30000);
        fail_count++;
        tally_and_finish();
    end
endmodule // tb_top

// file: shared/cmr_gap_if.sv
// carrier between result sequencer and message gap timer
`timescale 1ns/1ps
interface cmr_gap_if;
    logic msg_start;
    logic msg_end;
    logic [15:0] gap_us;
    logic gap_done;
    modport seq (output msg_start, output msg_end, output gap_us,
                 input gap_done);
    modport tmr (input msg_start, input msg_end, input gap_us,
                 output gap_done);
endinterface

// file: shared/cmr_pkg.sv
// constants for bus-controller message result and queue logic
package cmr_pkg;
    // ======================================================
    // host register map
    localparam logic [7:0] QPTR_OFS = 8'h1f;
    localparam logic [15:0] QPTR_RESET = 16'h0000;
    // ======================================================
    // message block word offsets
    localparam logic [15:0] WRD_BSW = 16'h0005;
    localparam logic [15:0] WRD_ECHO = 16'h0006;
    localparam logic [15:0] WRD_STAT = 16'h0007;
    localparam logic [15:0] WRD_STAT2 = 16'h0009;
    // ======================================================
    // block status word bit positions
    localparam int BSW_EOM = 15;
    localparam int BSW_SOM = 14;
    localparam int BSW_BUS_B = 13;
    localparam int BSW_ERR = 12;
    localparam int BSW_STSET = 11;
    localparam int BSW_FMT = 10;
    localparam int BSW_TMO = 9;
    localparam int BSW_LOOP = 8;
    localparam int BSW_UNMSK = 7;
    localparam int BSW_RTRY2 = 6;
    localparam int BSW_RTRY1 = 5;
    localparam int BSW_GOOD = 4;
    // ======================================================
    // returned terminal status bits and control word masks
    localparam int ST_ME = 10;
    localparam int ST_INSTR = 9;
    localparam int ST_SR = 8;
    localparam int ST_BROADCAST_RECEIVED_BIT = 4;
    localparam int ST_BUSY = 3;
    localparam int ST_SSF = 2;
    localparam int ST_DBCA = 1;
    localparam int ST_TF = 0;
    localparam int CW_SR = 13;
    localparam int CW_BUSY = 12;
    localparam int CW_SSF = 11;
    localparam int CW_TF = 10;
    localparam int CW_RSV = 9;
    localparam int CW_BROADCAST_RECEIVED_BIT = 5;
    // ======================================================
    // queue entry sources
    typedef enum logic [1:0] {
        CMR_Q_TTAG = 2'b00,
        CMR_Q_BSW = 2'b01,
        CMR_Q_IMM = 2'b10,
        CMR_Q_IND = 2'b11
    } cmr_qkind_e;
    localparam logic [5:0] QLOW_LAST = 6'h3f;
    // ======================================================
    // timing
    localparam int CLOCK_NS = 25;
    localparam int US_NS = 1000;
    localparam int DEFAULT_GAP_US = 10;
    localparam int US_CYCLES = (US_NS + CLOCK_NS - 1) / CLOCK_NS;
    localparam int GAP_CYCLES = (DEFAULT_GAP_US * US_NS) / CLOCK_NS;
endpackage

// file: src/cmr_gap_timer.sv
// time-to-next-message gap timer
`timescale 1ns/1ps
module cmr_gap_timer
    import cmr_pkg::*;
(
    input wire logic i_clock, // core clock
    input wire logic i_reset, // sync reset, high
    cmr_gap_if.tmr gap // start/end in, done out
);
    typedef enum logic [1:0] {
        G_IDLE = 2'b00,
        G_RUN = 2'b01,
        G_PROG = 2'b10,
        G_DFLT = 2'b11
    } cmr_gstate_e;
    localparam int DFLT_LAST = GAP_CYCLES - 1;
    localparam int USC_LAST = US_CYCLES - 1;

    cmr_gstate_e state;
    logic [5:0] sub;
    logic [15:0] elapsed;
    logic [15:0] target;
    logic [8:0] dflt;
    logic done;

    // ======================================================
    // microsecond tick, elapsed time saturates rather than wraps
    wire us_tick = (sub == USC_LAST[5:0]);
    wire prog_met = (elapsed >= target);
    // compare against the value taken at message start, not the live pin
    wire longer = (target > elapsed);
    assign gap.gap_done = done;

    // elapsed time counted from the start of the message
    always_ff @(posedge i_clock) begin
        if (i_reset || gap.msg_start || us_tick) begin
            sub <= 6'h00;
        end else begin
            sub <= sub + 6'h01;
        end
        if (i_reset || gap.msg_start) begin
            elapsed <= 16'h0000;
        end else if (us_tick && elapsed != 16'hffff) begin
            elapsed <= elapsed + 16'h0001;
        end
    end

    // short or zero programmed gap falls back to the default
    always_ff @(posedge i_clock) begin
        done <= 1'b0;
        if (i_reset) begin
            state <= G_IDLE;
            target <= 16'h0000;
            dflt <= 9'h000;
        end else if (gap.msg_start) begin
            state <= G_RUN;
            target <= gap.gap_us;
        end else begin
            case (state)
                G_RUN: begin
                    if (gap.msg_end && longer) begin
                        state <= G_PROG;
                    end else if (gap.msg_end) begin
                        state <= G_DFLT;
                        dflt <= 9'h000;
                    end
                end
                G_PROG: begin
                    if (prog_met) begin
                        done <= 1'b1;
                        state <= G_IDLE;
                    end
                end
                G_DFLT: begin
                    dflt <= dflt + 9'h001;
                    if (dflt == DFLT_LAST[8:0]) begin
                        done <= 1'b1;
                        state <= G_IDLE;
                    end
                end
                default: state <= G_IDLE;
            endcase
        end
    end

    default clocking @(posedge i_clock); endclocking
    default disable iff (i_reset);
    sequence dflt_entry;
        state == G_RUN && gap.msg_end && !longer && !gap.msg_start;
    endsequence
    dflt_gap_len_a: assert property (dflt_entry ##1 (!gap.msg_start)[*8]
        |-> !done)
        else $error("default gap ended early");
    prog_gap_a: assert property (done && state == G_IDLE &&
        $past(state) == G_PROG |-> $past(elapsed) >= $past(target))
        else $error("programmed gap ended before its time");
endmodule // cmr_gap_timer

// file: src/cmr_result_queue.sv
// bus-controller message result writer and general purpose queue
`timescale 1ns/1ps
// What this block does
// - set start-of-message bit when message begins
// - set end-of-message bit once message completes
// - bus bit: zero bus A, one bus B
// - error bit with cause bits on failure
// - busy line or bad command order: bare error
// - status set for any non-broadcast status bit
// - broadcast bit compared or masked per mode
// - format error bit on response violations
// - timeout bit for late or missing response
// - loop back bit on echo mismatch
// - unmasked status bit from control word masks
// - retry bits: six two retries, five one
// - good data bit for good transmit types
// - address, count, sync, word cause bits
// - last echo stored in word six
// - first returned status stored in word seven
// - second status stored in word nine
// - blocks eight word aligned, padding unused
// - host loads pointer, queue is 64 words
// - push advances only low six pointer bits
// - low bits wrapping raise queue wrap flag
// - four push sources: tag, status, value, indirect
// - next message after programmed time
// - short gap uses ten microsecond default
// - major frame auto repeat or host start
module cmr_result_queue
    import cmr_pkg::*;
(
    input wire logic i_clock, // core clock, 40 MHz
    input wire logic i_reset, // sync reset, high
    input wire logic [7:0] i_reg_addr, // register index
    input wire logic i_reg_write, // register write strobe
    input wire logic [15:0] i_reg_wdata, // register write data
    output logic [15:0] o_reg_rdata, // register read data
    input wire logic i_msg_start, // message execution begins
    input wire logic [15:0] i_msg_block, // message block pointer
    input wire logic i_msg_bus_b, // message on bus B
    input wire logic i_msg_terminal_to_terminal_transfer, // terminal_to_terminal_transfer
    input wire logic [15:0] i_ctrl_word, // message control word
    input wire logic i_broadcast_received_bit_mask_mode, // broadcast bit mask mode
    input wire logic [15:0] i_gap_us, // time to next message
    input wire logic i_msg_end, // message finished, results valid
    input wire logic i_res_line_busy, // other controller on line
    input wire logic i_res_order_err, // bad transfer command order
    input wire logic i_res_fmt, // response format violation
    input wire logic i_res_timeout, // response late or missing
    input wire logic i_res_loop_fail, // echo mismatch
    input wire logic [3:0] i_res_cause, // addr, count, sync, word
    input wire logic [1:0] i_res_retries, // retries performed
    input wire logic i_res_good_type, // type that returns data
    input wire logic i_res_status_valid, // status word returned
    input wire logic [15:0] i_res_status, // first returned status
    input wire logic [15:0] i_res_status2, // receiver status
    input wire logic [15:0] i_res_echo, // last transmitted echo
    input wire logic [15:0] i_time_tag, // current time tag
    output logic o_msg_complete, // block status written, pulse
    output logic o_next_msg_go, // gap elapsed, pulse
    input wire logic i_q_push, // queue push request
    input wire logic [1:0] i_q_kind, // push source
    input wire logic [15:0] i_q_param, // value or indirect address
    output logic o_q_busy, // push pending or in progress
    output logic o_q_wrap, // low pointer wrapped, pulse
    input wire logic i_frame_auto, // major frame repeats itself
    input wire logic i_frame_end, // major frame finished
    input wire logic i_frame_start, // host starts major frame
    output logic o_frame_restart, // begin major frame, pulse
    output logic o_mem_wr, // shared memory write
    output logic o_mem_rd, // shared memory read
    output logic [15:0] o_mem_addr, // shared memory address
    output logic [15:0] o_mem_wdata, // shared memory write data
    input wire logic [15:0] i_mem_rdata, // read data
    input wire logic i_mem_rvalid // read data valid
);
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_STAT = 3'b001,
        S_STAT2 = 3'b010,
        S_BSW = 3'b011,
        S_DONE = 3'b100,
        S_QWAIT = 3'b101,
        S_QADV = 3'b110
    } cmr_state_e;

    cmr_state_e state;
    cmr_gap_if gap_if ();
    logic start_p, end_p, q_p;
    logic [15:0] blk, bsw, echo, stat, stat2, qptr, q_param;
    logic bus_b, terminal_to_terminal_transfer, stat_ok;
    logic [1:0] q_kind;

    // ======================================================
    // returned status evaluation
    wire [15:0] st = i_res_status;
    wire [15:0] cw = i_ctrl_word;
    wire st_any = (|st[ST_ME:ST_BROADCAST_RECEIVED_BIT+1]) | (|st[ST_BUSY:ST_TF]);
    wire broadcast_received_bit_mis = i_broadcast_received_bit_mask_mode ? (st[ST_BROADCAST_RECEIVED_BIT] & ~cw[CW_BROADCAST_RECEIVED_BIT])
                                     : (st[ST_BROADCAST_RECEIVED_BIT] != cw[CW_BROADCAST_RECEIVED_BIT]);
    wire st_set = i_res_status_valid & (st_any | broadcast_received_bit_mis);
    // instruction, error and acceptance bits have no mask
    wire st_unm_raw = (st[ST_SR] & ~cw[CW_SR])
        | (st[ST_BUSY] & ~cw[CW_BUSY]) | (st[ST_SSF] & ~cw[CW_SSF])
        | (st[ST_TF] & ~cw[CW_TF])
        | ((|st[ST_SR-1:ST_BROADCAST_RECEIVED_BIT+1]) & ~cw[CW_RSV])
        | st[ST_ME] | st[ST_INSTR] | st[ST_DBCA]
        | (i_broadcast_received_bit_mask_mode & st[ST_BROADCAST_RECEIVED_BIT] & ~cw[CW_BROADCAST_RECEIVED_BIT]);
    wire st_unm = i_res_status_valid & st_unm_raw;
    // loop back failure is kept out of the good data decision
    wire err_nl = i_res_fmt | i_res_timeout | (|i_res_cause)
                | i_res_line_busy | i_res_order_err;
    wire err = err_nl | i_res_loop_fail;
    wire good = i_res_good_type & ~err_nl;
    wire rtry2 = (i_res_retries == 2'd2);
    wire rtry1 = (i_res_retries == 2'd1);
    wire [15:0] next_bsw = {1'b1, 1'b1, bus_b, err, st_set, i_res_fmt,
        i_res_timeout, i_res_loop_fail, st_unm, rtry2, rtry1, good,
        i_res_cause};

    // ======================================================
    // queue entry source selection and pointer advance
    wire [15:0] q_entry = (q_kind == CMR_Q_TTAG) ? i_time_tag
                        : (q_kind == CMR_Q_BSW) ? bsw : q_param;
    wire q_wrap_now = (qptr[5:0] == QLOW_LAST);
    wire [15:0] qptr_inc = {qptr[15:6], qptr[5:0] + 6'h01};
    wire reg_hit = (i_reg_addr == QPTR_OFS);
    assign o_q_busy = q_p | (state == S_QWAIT) | (state == S_QADV);

    // ======================================================
    // gap timer hookup
    assign gap_if.msg_start = i_msg_start;
    assign gap_if.msg_end = i_msg_end;
    assign gap_if.gap_us = i_gap_us;
    cmr_gap_timer u_gap (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .gap(gap_if.tmr)
    );

    // request capture; a new request wins over the clear that serves
    // an older one
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            start_p <= 1'b0;
            end_p <= 1'b0;
            q_p <= 1'b0;
        end else begin
            start_p <= i_msg_start | (start_p & ~(state == S_IDLE));
            end_p <= i_msg_end | (end_p & ~(state == S_IDLE && !start_p));
            q_p <= i_q_push | (q_p & ~(state == S_IDLE && !start_p
                                        && !end_p));
        end
    end

    // message and result capture
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            blk <= 16'h0000;
            bus_b <= 1'b0;
            terminal_to_terminal_transfer <= 1'b0;
            bsw <= 16'h0000;
            echo <= 16'h0000;
            stat <= 16'h0000;
            stat2 <= 16'h0000;
            stat_ok <= 1'b0;
            q_kind <= 2'b00;
            q_param <= 16'h0000;
        end else begin
            if (i_msg_start) begin
                blk <= {i_msg_block[15:3], 3'b000};
                bus_b <= i_msg_bus_b;
                terminal_to_terminal_transfer <= i_msg_terminal_to_terminal_transfer;
            end
            if (i_msg_end) begin
                bsw <= next_bsw;
                echo <= i_res_echo;
                stat <= i_res_status;
                stat2 <= i_res_status2;
                stat_ok <= i_res_status_valid;
            end
            if (i_q_push) begin
                q_kind <= i_q_kind;
                q_param <= i_q_param;
            end
        end
    end

    // ======================================================
    // memory sequencer: start word, then echo, status, block status
    always_ff @(posedge i_clock) begin
        o_mem_wr <= 1'b0;
        o_mem_rd <= 1'b0;
        o_msg_complete <= 1'b0;
        if (i_reset) begin
            state <= S_IDLE;
            o_mem_addr <= 16'h0000;
            o_mem_wdata <= 16'h0000;
        end else begin
            case (state)
                S_IDLE: begin
                    if (start_p) begin
                        o_mem_wr <= 1'b1;
                        o_mem_addr <= blk | WRD_BSW;
                        o_mem_wdata <= {1'b0, 1'b1, bus_b, 13'h0000};
                    end else if (end_p) begin
                        o_mem_wr <= 1'b1;
                        o_mem_addr <= blk | WRD_ECHO;
                        o_mem_wdata <= echo;
                        state <= S_STAT;
                    end else if (q_p && q_kind == CMR_Q_IND) begin
                        o_mem_rd <= 1'b1;
                        o_mem_addr <= q_param;
                        state <= S_QWAIT;
                    end else if (q_p) begin
                        o_mem_wr <= 1'b1;
                        o_mem_addr <= qptr;
                        o_mem_wdata <= q_entry;
                        state <= S_QADV;
                    end
                end
                S_STAT: begin
                    o_mem_wr <= stat_ok;
                    o_mem_addr <= blk | WRD_STAT;
                    o_mem_wdata <= stat;
                    state <= terminal_to_terminal_transfer ? S_STAT2 : S_BSW;
                end
                S_STAT2: begin
                    o_mem_wr <= 1'b1;
                    o_mem_addr <= blk | WRD_STAT2;
                    o_mem_wdata <= stat2;
                    state <= S_BSW;
                end
                S_BSW: begin
                    o_mem_wr <= 1'b1;
                    o_mem_addr <= blk | WRD_BSW;
                    o_mem_wdata <= bsw;
                    state <= S_DONE;
                end
                S_DONE: begin
                    o_msg_complete <= 1'b1;
                    state <= S_IDLE;
                end
                S_QWAIT: begin
                    if (i_mem_rvalid) begin
                        o_mem_wr <= 1'b1;
                        o_mem_addr <= qptr;
                        o_mem_wdata <= i_mem_rdata;
                        state <= S_QADV;
                    end
                end
                S_QADV: state <= S_IDLE;
                default: state <= S_IDLE;
            endcase
        end
    end

    // queue pointer; a host load beats an advance in the same cycle
    always_ff @(posedge i_clock) begin
        o_q_wrap <= 1'b0;
        if (i_reset) begin
            qptr <= QPTR_RESET;
        end else if (i_reg_write && reg_hit) begin
            qptr <= i_reg_wdata;
        end else if (state == S_QADV) begin
            qptr <= qptr_inc;
            o_q_wrap <= q_wrap_now;
        end
    end

    // register read back and frame control
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_reg_rdata <= 16'h0000;
            o_next_msg_go <= 1'b0;
            o_frame_restart <= 1'b0;
        end else begin
            o_reg_rdata <= reg_hit ? qptr : 16'h0000;
            o_next_msg_go <= gap_if.gap_done;
            o_frame_restart <= i_frame_start
                             | (i_frame_end & i_frame_auto);
        end
    end

    // ======================================================
    // checks
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_reset);
    wire final_wr = o_mem_wr && o_mem_wdata[BSW_EOM]
                 && o_mem_addr[2:0] == WRD_BSW[2:0];
    sequence tail_writes;
        final_wr ##1 o_msg_complete;
    endsequence
    som_write_a: assert property (state == S_IDLE && start_p |=>
        o_mem_wr && o_mem_wdata[BSW_SOM] && !o_mem_wdata[BSW_EOM])
        else $error("start bit not written");
    eom_order_a: assert property (o_msg_complete |->
        $past(final_wr))
        else $error("completion before block status");
    done_follow_a: assert property (state == S_BSW |=> tail_writes)
        else $error("final block status not written");
    bus_bit_a: assert property (final_wr |->
        o_mem_wdata[BSW_BUS_B] == bus_b)
        else $error("bus bit wrong");
    err_bit_a: assert property (i_msg_end && i_res_line_busy |=>
        bsw[BSW_ERR] && bsw[3:0] == 4'h0)
        else $error("busy line not flagged as bare error");
    tmo_bit_a: assert property (i_msg_end |=>
        bsw[BSW_TMO] == $past(i_res_timeout)
        && bsw[BSW_ERR] == $past(err))
        else $error("timeout or error bit wrong");
    good_loop_a: assert property (i_msg_end && i_res_good_type
        && !err_nl && i_res_loop_fail |=> bsw[BSW_GOOD])
        else $error("loop back failure cleared good bit");
    ptr_upper_a: assert property (state == S_QADV && !i_reg_write |=>
        qptr[15:6] == $past(qptr[15:6])
        && qptr[5:0] == $past(qptr[5:0]) + 6'h01)
        else $error("pointer advance wrong");
    wrap_pulse_a: assert property (o_q_wrap |->
        $past(qptr[5:0]) == QLOW_LAST)
        else $error("wrap flagged without wrap");
    q_write_a: assert property (state == S_QADV |->
        o_mem_wr && o_mem_addr == qptr)
        else $error("queue entry not at pointer");
endmodule // cmr_result_queue
